/* design/scr_cfg.svh */
// Purpose: Constants for the command result reporting block
// Assumes: APB word-aligned register offsets
// Notes:   Offsets, codes and fields are named here only
`ifndef SCR_CFG_SVH
`define SCR_CFG_SVH

`define SCR_OFF_COMMAND   12'h000
`define SCR_OFF_RESULT    12'h004
`define SCR_OFF_EVENTS    12'h008
`define SCR_OFF_IRQ_STAT  12'h00C
`define SCR_OFF_IRQ_MASK  12'h010
`define SCR_OFF_ALS_IRQ   12'h014

`define SCR_CMD_NO_OP     8'h00
`define SCR_RES_ZERO      8'h00
`define SCR_RES_INVALID   8'h80
`define SCR_RES_OVF_PROX1 8'h88
`define SCR_RES_OVF_PROX2 8'h89
`define SCR_RES_OVF_PROX3 8'h8A
`define SCR_RES_OVF_VIS   8'h8C
`define SCR_RES_OVF_IR    8'h8D
`define SCR_RES_OVF_AUX   8'h8E

`define SCR_CNT_ZERO      4'h0
`define SCR_CNT_ONE       4'h1
`define SCR_ERR_NONE      4'h0
`define SCR_EXEC_CYCLES   4'h3
`define SCR_IRQ_W         3
`define SCR_ALS_W         2
`define SCR_AMB_HI        3
`define SCR_AMB_LO        2

`endif

/* design/scr_pkg.sv */
// Purpose: Types for the command result reporting block
// Assumes: Constants come from scr_cfg.svh
// Notes:   Holds the sequencer state type only
package scr_pkg;
    typedef enum logic [1:0] {
        SCR_STANDBY,
        SCR_EXEC,
        SCR_REPORT
    } scr_state_t;
endpackage : scr_pkg

/* design/scr_top.sv */
// Purpose: Result byte reporting behind an APB register file
// Assumes: One clock, synchronous active-high reset, APB3 master
// Notes:   Overflow and invalid-setting events come in on input pins
`include "scr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module scr_top
    import scr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        invalid_setting,
    input  wire logic        proximity_one_conversion_overflow,
    input  wire logic        proximity_two_conversion_overflow,
    input  wire logic        proximity_three_conversion_overflow,
    input  wire logic        visible_light_conversion_overflow,
    input  wire logic        infrared_light_conversion_overflow,
    input  wire logic        aux_conversion_overflow,
    input  wire logic [1:0]  ambient_light_event,
    output logic             seq_busy,
    output logic             irq
);

    // Pin-level event inputs pass two flops first
    logic [6:0] err_meta_reg;
    logic [6:0] err_sync_reg;
    logic [1:0] als_meta_reg;
    logic [1:0] als_sync_reg;

    scr_state_t state_reg;
    scr_state_t state_next;
    logic [7:0] cmd_reg;
    logic [7:0] result_reg;
    logic [7:0] result_next;
    logic [3:0] exec_cnt_reg;
    logic [3:0] exec_cnt_next;
    logic [7:0] err_pend_reg;
    logic [7:0] err_pend_next;
    logic [`SCR_IRQ_W-1:0] irq_stat_reg;
    logic [`SCR_IRQ_W-1:0] irq_stat_next;
    logic [`SCR_IRQ_W-1:0] irq_mask_reg;
    logic [`SCR_ALS_W-1:0] amb_stat_reg;
    logic [`SCR_ALS_W-1:0] amb_stat_next;
    logic [`SCR_ALS_W-1:0] amb_en_reg;
    logic [31:0] prdata_next;

    function automatic logic [7:0] err_code(input logic [6:0] ev);
        // Lowest index wins when several arrive together
        if (ev[0])
            err_code = `SCR_RES_INVALID;
        else if (ev[1])
            err_code = `SCR_RES_OVF_PROX1;
        else if (ev[2])
            err_code = `SCR_RES_OVF_PROX2;
        else if (ev[3])
            err_code = `SCR_RES_OVF_PROX3;
        else if (ev[4])
            err_code = `SCR_RES_OVF_VIS;
        else if (ev[5])
            err_code = `SCR_RES_OVF_IR;
        else if (ev[6])
            err_code = `SCR_RES_OVF_AUX;
        else
            err_code = `SCR_RES_ZERO;
    endfunction : err_code

    function automatic logic is_err(input logic [7:0] code);
        is_err = (code[7:4] != `SCR_ERR_NONE);
    endfunction : is_err

    wire logic [6:0] err_raw = {aux_conversion_overflow,
                                infrared_light_conversion_overflow,
                                visible_light_conversion_overflow,
                                proximity_three_conversion_overflow,
                                proximity_two_conversion_overflow,
                                proximity_one_conversion_overflow,
                                invalid_setting};

    wire logic acc     = psel & penable;
    wire logic wr_acc  = acc & pwrite;
    wire logic hit_cmd  = (paddr == `SCR_OFF_COMMAND);
    wire logic hit_res  = (paddr == `SCR_OFF_RESULT);
    wire logic hit_evt  = (paddr == `SCR_OFF_EVENTS);
    wire logic hit_stat = (paddr == `SCR_OFF_IRQ_STAT);
    wire logic hit_mask = (paddr == `SCR_OFF_IRQ_MASK);
    wire logic hit_als  = (paddr == `SCR_OFF_ALS_IRQ);
    wire logic mapped   = hit_cmd | hit_res | hit_evt | hit_stat
                        | hit_mask | hit_als;
    wire logic cmd_wr   = wr_acc & hit_cmd;
    wire logic no_op_wr = cmd_wr & (pwdata[7:0] == `SCR_CMD_NO_OP);
    wire logic stat_wr  = wr_acc & hit_stat;
    wire logic mask_wr  = wr_acc & hit_mask;
    wire logic amb_wr   = wr_acc & hit_als;
    // Only a read setup reloads the read buffer
    wire logic rd_setup = psel & ~penable & ~pwrite;
    wire logic [7:0] new_err = err_code(err_sync_reg);
    wire logic err_seen = is_err(new_err);
    wire logic shown_err = is_err(result_reg);
    wire logic done_evt = (state_reg == SCR_REPORT);

    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;
    assign seq_busy = (state_reg != SCR_STANDBY);
    assign irq = |(irq_stat_reg & irq_mask_reg)
               | |(amb_stat_reg & amb_en_reg);

    // Sequencer: any command write other than no-operation wakes it, result updated when done
    always_comb
    begin
        state_next    = state_reg;
        exec_cnt_next = exec_cnt_reg;
        case (state_reg)
            SCR_STANDBY:
            begin
                if (cmd_wr && !no_op_wr)
                begin
                    state_next    = SCR_EXEC;
                    exec_cnt_next = `SCR_EXEC_CYCLES;
                end
            end
            SCR_EXEC:
            begin
                // No-operation aborts a running command
                if (no_op_wr)
                    state_next = SCR_STANDBY;
                else if (exec_cnt_reg == `SCR_CNT_ZERO)
                    state_next = SCR_REPORT;
                else
                    exec_cnt_next = exec_cnt_reg - `SCR_CNT_ONE;
            end
            SCR_REPORT:
                state_next = SCR_STANDBY;
            default:
                state_next = SCR_STANDBY;
        endcase
    end

    // Pending error latched until it can be shown
    always_comb
    begin
        err_pend_next = err_pend_reg;
        if (err_seen && !is_err(err_pend_reg))
            err_pend_next = new_err;
        else if (no_op_wr || (!shown_err && is_err(err_pend_reg)))
            err_pend_next = `SCR_RES_ZERO;
    end

    always_comb
    begin
        result_next = result_reg;
        // Error codes stick; only the no-operation command clears
        if (no_op_wr)
            result_next = `SCR_RES_ZERO;
        else if (shown_err)
            result_next = result_reg;
        else if (is_err(err_pend_reg))
            result_next = err_pend_reg;
        else if (done_evt)
            result_next = {`SCR_ERR_NONE, result_reg[3:0] + `SCR_CNT_ONE};
    end

    // Sticky status: events set, write one clears, set wins
    always_comb
    begin
        irq_stat_next = irq_stat_reg;
        amb_stat_next = amb_stat_reg;
        if (stat_wr)
            irq_stat_next = irq_stat_reg & ~pwdata[`SCR_IRQ_W-1:0];
        if (amb_wr)
            amb_stat_next = amb_stat_reg & ~pwdata[`SCR_ALS_W-1:0];
        // Set after clear so an event in the clear cycle is kept
        irq_stat_next = irq_stat_next
                      | {err_seen && !err_sync_reg[0], err_sync_reg[0],
                         done_evt};
        amb_stat_next = amb_stat_next | als_sync_reg;
    end

    always_comb
    begin
        prdata_next = 32'h0000_0000;
        if (hit_cmd)
            prdata_next[7:0] = cmd_reg;
        else if (hit_res)
            prdata_next[7:0] = result_reg;
        else if (hit_evt)
            prdata_next[6:0] = err_sync_reg;
        else if (hit_stat)
            prdata_next[`SCR_IRQ_W-1:0] = irq_stat_reg;
        else if (hit_mask)
            prdata_next[`SCR_IRQ_W-1:0] = irq_mask_reg;
        else if (hit_als)
            prdata_next[`SCR_AMB_HI:0] = {amb_en_reg, amb_stat_reg};
    end

    always_ff @(posedge clk)
    begin
        err_meta_reg <= err_raw;
        err_sync_reg <= err_meta_reg;
        als_meta_reg <= ambient_light_event;
        als_sync_reg <= als_meta_reg;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_reg    <= SCR_STANDBY;
            exec_cnt_reg <= `SCR_CNT_ZERO;
        end
        else
        begin
            state_reg    <= state_next;
            exec_cnt_reg <= exec_cnt_next;
        end
    end

    // Result and its pending error move together
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            result_reg   <= `SCR_RES_ZERO;
            err_pend_reg <= `SCR_RES_ZERO;
        end
        else
        begin
            result_reg   <= result_next;
            err_pend_reg <= err_pend_next;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            irq_stat_reg <= '0;
            amb_stat_reg <= '0;
        end
        else
        begin
            irq_stat_reg <= irq_stat_next;
            amb_stat_reg <= amb_stat_next;
        end
    end

    // Software-written fields: command, mask and ambient enable
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cmd_reg      <= `SCR_CMD_NO_OP;
            irq_mask_reg <= '0;
            amb_en_reg   <= '0;
        end
        else
        begin
            if (cmd_wr)
                cmd_reg <= pwdata[7:0];
            if (mask_wr)
                irq_mask_reg <= pwdata[`SCR_IRQ_W-1:0];
            if (amb_wr)
                amb_en_reg <= pwdata[`SCR_AMB_HI:`SCR_AMB_LO];
        end
    end

    // Read data is launched in the setup cycle, so it is
    // settled for the whole access phase at no wait states
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            prdata <= 32'h0000_0000;
        else if (rd_setup)
            prdata <= prdata_next;
    end

endmodule : scr_top
`default_nettype wire

/* testbench/scr_chk.sv */
// Purpose: Port checker for the result block
// Assumes: Zero wait-state bus
// Notes:   Bound to scr_top
`timescale 1ns/1ps
`default_nettype none
module scr_chk (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        seq_busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire logic rs  = psel && !penable && !pwrite;
    wire logic acc = psel && penable;
    wire logic cw  = acc && pwrite && paddr == 12'h000;
    wire logic unm = paddr[1:0] != 2'h0 || paddr > 12'h014;
    slverr_unmapped_a: assert property (acc && unm |-> pslverr)
        else $error("no slave error");
    unmapped_read_a: assert property (rs && unm |=> prdata == 32'h0)
        else $error("unmapped read not zero");
    busy_window_a: assert property (
        cw && pwdata[7:0] != 8'h00 && !seq_busy |=> seq_busy[*5] ##1 !seq_busy)
        else $error("busy window wrong");
    noop_abort_a: assert property (
        cw && pwdata[7:0] == 8'h00 |=> !seq_busy)
        else $error("no-op left busy");
    noop_result_a: assert property (
        cw && pwdata[7:0] == 8'h00 ##[1:2] rs && paddr == 12'h004
        |=> prdata[7:0] == 8'h00) else $error("result not cleared");
    result_code_a: assert property (
        rs && paddr == 12'h004 |=> prdata[7:4] == 4'h0 || prdata[7:0] inside
        {8'h80, 8'h88, 8'h89, 8'h8A, 8'h8C, 8'h8D, 8'h8E})
        else $error("bad result code");
    upper_zero_a: assert property (rs |=> prdata[31:8] == 24'h0)
        else $error("upper bits set");
    als_field_a: assert property (
        rs && paddr == 12'h014 |=> prdata[31:4] == 0)
        else $error("ambient field too wide");
endmodule : scr_chk
bind scr_top scr_chk chk_u (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pslverr(pslverr), .seq_busy(seq_busy));
`default_nettype wire

/* testbench/scr_host.sv */
// Purpose: Host model driving the register bus
// Assumes: pready sampled at rising edge
// Notes:   Tasks called from the bench
`timescale 1ns/1ps
`default_nettype none
module scr_host (
    input  wire logic        clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    logic [31:0] rdat;
    logic        rerr;
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    // Restarts the whole handshake after a silent spell
    task automatic command(input logic [7:0] c);
        int n;
        do
        begin
            xfer(1'b1, 12'h000, 32'h0);
            xfer(1'b0, 12'h004, 32'h0);
            xfer(1'b1, 12'h000, {24'h0, c});
            n = 0;
            do
            begin
                xfer(1'b0, 12'h004, 32'h0);
                n++;
            end
            while (rdat[7:0] === 8'h00 && n < 40);
        end
        while (rdat[7:0] === 8'h00);
    endtask : command
endmodule : scr_host
`default_nettype wire

/* testbench/sensor_command_result_reporting_tb.sv */
// Purpose: Self-checking bench for the result block
// Assumes: Host model owns the register bus
// Notes:   Events held long enough for synchronisers
`timescale 1ns/1ps
`default_nettype none
module sensor_command_result_reporting_tb;
    logic             clk;
    logic             sys_rst;
    logic [6:0]       ev;
    logic [1:0]       als;
    wire logic        psel, penable, pwrite, pready, pslverr, seq_busy, irq;
    wire logic [11:0] paddr;
    wire logic [31:0] pwdata, prdata;
    int               fail_count, num_checks, cyc;
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    scr_host host_u (.clk(clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    scr_top dut_u (.clk(clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .invalid_setting(ev[0]), .proximity_one_conversion_overflow(ev[1]),
        .proximity_two_conversion_overflow(ev[2]),
        .proximity_three_conversion_overflow(ev[3]),
        .visible_light_conversion_overflow(ev[4]),
        .infrared_light_conversion_overflow(ev[5]),
        .aux_conversion_overflow(ev[6]), .ambient_light_event(als),
        .seq_busy(seq_busy), .irq(irq));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        host_u.xfer(1'b0, a, 32'h0);
        chk(host_u.rdat, exp);
    endtask : rd
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        host_u.xfer(1'b1, a, d);
    endtask : wr
    task automatic final_report;
        $display("checks=%0d errors=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report
    task automatic t_reset;
        rd(12'h004, 32'h0);
        rd(12'h014, 32'h0);
        rd(12'h100, 32'h0);
        chk({31'h0, host_u.rerr}, 32'h1);
    endtask : t_reset
    task automatic t_count;
        host_u.command(8'h05);
        chk(host_u.rdat, 32'h1);
        for (int i = 2; i <= 17; i++)
        begin
            wr(12'h000, 32'h07);
            repeat (6) @(posedge clk);
            rd(12'h004, 32'(i % 16));
        end
        rd(12'h00C, 32'h1);
        wr(12'h010, 32'h1);
        @(negedge clk);
        chk({31'h0, irq}, 32'h1);
        wr(12'h00C, 32'h1);
        @(negedge clk);
        chk({31'h0, irq}, 32'h0);
        wr(12'h000, 32'h0);
        rd(12'h004, 32'h0);
    endtask : t_count
    task automatic t_err;
        logic [7:0] code [7] = '{8'h80, 8'h88, 8'h89, 8'h8A,
                                 8'h8C, 8'h8D, 8'h8E};
        for (int i = 0; i < 7; i++)
        begin
            ev <= 7'(1 << i);
            repeat (6) @(posedge clk);
            ev <= 7'h0;
            repeat (4) @(posedge clk);
            rd(12'h004, {24'h0, code[i]});
            wr(12'h000, 32'h05);
            repeat (6) @(posedge clk);
            rd(12'h004, {24'h0, code[i]});
            wr(12'h000, 32'h0);
            rd(12'h004, 32'h0);
        end
    endtask : t_err
    task automatic t_als;
        // Completions of earlier scenarios are still flagged and unmasked
        wr(12'h00C, 32'h7);
        als <= 2'h2;
        repeat (5) @(posedge clk);
        als <= 2'h0;
        repeat (3) @(posedge clk);
        rd(12'h014, 32'h2);
        @(negedge clk);
        chk({31'h0, irq}, 32'h0);
        wr(12'h014, 32'h8);
        @(negedge clk);
        chk({31'h0, irq}, 32'h1);
        wr(12'h014, 32'hA);
        @(negedge clk);
        chk({31'h0, irq}, 32'h0);
    endtask : t_als
    initial
    begin
        sys_rst = 1'b1;
        ev = 7'h0;
        als = 2'h0;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset;
        t_count;
        t_err;
        t_als;
        final_report;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            fail_count++;
            final_report;
        end
    end
endmodule : sensor_command_result_reporting_tb
`default_nettype wire
